/* File: src/operand_params.svh */
// Offsets, field positions and reset values of the operand modifier.
// Assumes a 32-bit AHB-Lite slave decoding the low address byte.
`ifndef OPERAND_PARAMS_SVH
`define OPERAND_PARAMS_SVH

`define INSTR_W 24
`define WADDR_W 15
`define CADDR_W 17

`define OFF_INSTR0 8'h00
`define OFF_INSTR1 8'h04
`define OFF_INSTR2 8'h08
`define OFF_IND 8'h0c
`define OFF_IDX1 8'h10
`define OFF_CTRL 8'h1c
`define OFF_CHAR 8'h20
`define OFF_ADDR_A 8'h24
`define OFF_ADDR_C 8'h28
`define OFF_FIELDS 8'h2c
`define OFF_STATUS 8'h30
`define OFF_MASK 8'h34
`define OFF_EFF 8'h38

`define CTRL_BWORD 2
`define CTRL_DELIM8 3
`define CTRL_WC_HI 5
`define CTRL_WC_LO 4
`define CTRL_START 8
`define CTRL_FINISH 9
`define CTRL_RST 10'h010

`define ST_DONE 0
`define ST_DELIM 1
`define ST_CMPL 2
`define ST_CNTERR 3
`define ST_W 4
`define MASK_RST 4'h0

`define F_A 17
`define F_B_HI 16
`define F_B_LO 15
`define F_CB_HI 19
`define F_CB_LO 18
`define F_BF_HI 18
`define F_BF_LO 17
`define F_CH_HI 17
`define F_CH_LO 15
`define F_INT 14
`define F_WCC 13
`define IND_BITS 18

`endif

/* File: src/operand_pkg.sv */
// Types shared by the operand modifier modules.
// Assumes operand_params.svh supplies the numeric constants.
package operand_pkg;

    typedef enum logic [1:0] {
        fmt_word = 2'h0,
        fmt_char = 2'h1,
        fmt_shift = 2'h2,
        fmt_business = 2'h3
    } format_t;

    typedef enum logic [1:0] {
        st_idle = 2'b01,
        st_active = 2'b10
    } op_state_t;

endpackage

/* File: src/index_lane_if.sv */
// Carrier between the decoder and its index adder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/10ps
interface index_lane_if;
    logic [16:0] idx [3];
    logic business;
    logic [1:0] sel [2];
    logic [16:0] base [2];
    logic [16:0] sum [2];

    modport requester (output idx, business, sel, base, input sum);
    modport adder (input idx, business, sel, base, output sum);
endinterface

/* File: src/index_adder.sv */
// Two-lane index adder: picks an index register by flag and adds it.
// Assumes the requester masks the sum down to the target width.
`timescale 1ns/10ps
module index_adder
    import operand_pkg::*;
(
    index_lane_if.adder lane
);

    generate
        for (genvar i = 0; i < 2; i++) begin : g_lane
            wire [1:0] flag = lane.sel[i];
            // Business flags fold 3 onto index register 1
            wire [1:0] pick = (lane.business && flag == 2'h3) ? 2'h1 : flag;
            wire [1:0] slot = pick - 2'h1;
            wire [16:0] addend = (pick == 2'h0) ? 17'h00000 : lane.idx[slot];
            // Carry out of the top bit is simply lost
            assign lane.sum[i] = lane.base[i] + addend; // [RL17]
        end
    endgenerate

endmodule

/* File: src/operand_address_modifier.sv */
// Instruction parameter decoder and operand address modifier.
// Assumes one AHB-Lite master; index adder on an index_lane_if.
// Notes on behaviour
// RL1 - Words are 24 bits, one to three words
// RL2 - Mode flag zero direct, one indirect
// RL3 - Index designator picks register one to three
// RL4 - Word address plus index gives 15 bits
// RL5 - Field A flag: 1/3 B1, 2 B2, 0 none
// RL6 - Field C uses same flag decoding
// RL7 - Word-addressed fields index by own flag
// RL8 - Shift count plus designated index register
// RL9 - Matching delimiter character ends the operation
// RL10 - Channel field selects channel zero to seven
// RL11 - Completion flag raises interrupt at end
// RL12 - Input word count control flag enables
// RL13 - Group field selects interrupt group 0-7
// RL14 - Character address splits word and designator
// RL15 - Indirect replaces low 18 instruction bits
// RL16 - Character address plus designated index register
// RL17 - Sums truncate to target field width
// RL18 - Unused zero areas are ignored
`timescale 1ns/10ps
`include "operand_params.svh"
module operand_address_modifier
    import operand_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq
);

    index_lane_if lane ();

    index_adder u_adder (
        .lane(lane)
    );

    // Bus slave: one wait state so read data leave a flip-flop
    logic stage_reg;
    logic write_reg;
    logic [7:0] addr_reg;
    logic [31:0] hrdata_reg;
    wire accept = hsel & htrans[1] & hready;
    wire wr_en = stage_reg & write_reg;
    wire rd_en = stage_reg & ~write_reg;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            stage_reg <= 1'b0;
            write_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            stage_reg <= accept;
            if (accept) begin
                write_reg <= hwrite;
                addr_reg <= haddr[7:0];
            end
        end
    end

    assign hreadyout = ~stage_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    wire wr_instr0 = wr_en & (addr_reg == `OFF_INSTR0);
    wire wr_instr1 = wr_en & (addr_reg == `OFF_INSTR1);
    wire wr_instr2 = wr_en & (addr_reg == `OFF_INSTR2);
    wire wr_ind = wr_en & (addr_reg == `OFF_IND);
    wire wr_ctrl = wr_en & (addr_reg == `OFF_CTRL);
    wire wr_char = wr_en & (addr_reg == `OFF_CHAR);
    wire wr_status = wr_en & (addr_reg == `OFF_STATUS);
    wire wr_mask = wr_en & (addr_reg == `OFF_MASK);

    // Instruction words and the word fetched for indirect addressing
    logic [23:0] instr0_reg;
    logic [23:0] instr1_reg;
    logic [23:0] instr2_reg;
    logic [23:0] ind_reg;
    logic [9:0] ctrl_reg;
    logic [3:0] mask_reg;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            instr0_reg <= 24'h000000;
            instr1_reg <= 24'h000000;
            instr2_reg <= 24'h000000;
            ind_reg <= 24'h000000;
            ctrl_reg <= `CTRL_RST;
            mask_reg <= `MASK_RST;
        end else begin
            // Only the low 24 bits form an instruction word
            if (wr_instr0) instr0_reg <= hwdata[23:0]; // [RL1]
            if (wr_instr1) instr1_reg <= hwdata[23:0];
            if (wr_instr2) instr2_reg <= hwdata[23:0];
            if (wr_ind) ind_reg <= hwdata[23:0];
            // Start and finish are strobes and never stay set
            if (wr_ctrl) ctrl_reg <= {2'b00, hwdata[7:0]};
            if (wr_mask) mask_reg <= hwdata[3:0];
        end
    end

    logic [16:0] idx_reg [3];
    generate
        for (genvar i = 0; i < 3; i++) begin : g_idx
            wire wr_idx = wr_en & (addr_reg == `OFF_IDX1 + 8'(4 * i));
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    idx_reg[i] <= 17'h00000;
                end else if (wr_idx) begin
                    idx_reg[i] <= hwdata[16:0];
                end
            end
            assign lane.idx[i] = idx_reg[i]; // [RL3]
        end
    endgenerate

    // Decoding of the control word
    // A start write decodes its own format, not the one it replaces
    wire [7:0] ctrl_now = wr_ctrl ? hwdata[7:0] : ctrl_reg[7:0];
    wire [1:0] fmt_bits = ctrl_now[1:0];
    wire is_word = fmt_bits == fmt_word;
    wire is_char = fmt_bits == fmt_char;
    wire is_biz = fmt_bits == fmt_business;
    wire biz_word = ctrl_now[`CTRL_BWORD];
    wire delim8 = ctrl_now[`CTRL_DELIM8];
    wire [1:0] words = ctrl_now[`CTRL_WC_HI:`CTRL_WC_LO];
    wire start = wr_ctrl & hwdata[`CTRL_START];
    wire finish = wr_ctrl & hwdata[`CTRL_FINISH];
    // A business instruction always spans all three words
    wire words_ok = (words != 2'h0) && (!is_biz || words == 2'h3); // [RL1]
    wire start_ok = start & words_ok;

    // Indirect word replaces the low 18 bits; opcode bits are kept
    wire [23:0] ind_word = {instr0_reg[23:`IND_BITS],
                            ind_reg[`IND_BITS-1:0]}; // [RL15]
    wire [23:0] eff_word = instr0_reg[`F_A] ? ind_word : instr0_reg; // [RL2]
    // Shift and character forms have no indirect variant
    wire [23:0] word_src = is_word ? eff_word : instr0_reg;
    wire [1:0] word_b = word_src[`F_B_HI:`F_B_LO];
    wire [16:0] word_m = {2'b00, word_src[`WADDR_W-1:0]}; // [RL4] [RL8]
    // Word-addressed business fields take bits 02-16 of each word
    wire [16:0] field_a = biz_word ? {2'b00, instr1_reg[16:2]}
                                   : instr1_reg[16:0]; // [RL7] [RL14]
    wire [16:0] field_c = biz_word ? {2'b00, instr2_reg[16:2]}
                                   : instr2_reg[16:0]; // [RL7] [RL14]

    assign lane.business = is_biz;
    assign lane.sel[0] = is_biz ? instr1_reg[`F_BF_HI:`F_BF_LO]
                       : is_char ? instr0_reg[`F_CB_HI:`F_CB_LO]
                       : word_b; // [RL5] [RL3]
    assign lane.base[0] = is_biz ? field_a
                        : is_char ? instr0_reg[16:0]
                        : word_m; // [RL16]
    assign lane.sel[1] = instr2_reg[`F_BF_HI:`F_BF_LO]; // [RL6]
    assign lane.base[1] = field_c;

    // Character results keep all 17 bits, word results only 15
    wire char_wide = is_char | (is_biz & ~biz_word);
    wire [16:0] addr_a_next = char_wide ? lane.sum[0]
                            : {2'b00, lane.sum[0][14:0]}; // [RL17] [RL4]
    wire [16:0] addr_c_next = !is_biz ? 17'h00000
                            : biz_word ? {2'b00, lane.sum[1][14:0]}
                            : lane.sum[1]; // [RL6] [RL17]

    // Fields latched at start; bits a format leaves unused are ignored
    logic [16:0] addr_a_reg;
    logic [16:0] addr_c_reg;
    logic [23:0] eff_reg;
    logic [12:0] fields_reg;
    wire [2:0] chan = eff_word[`F_CH_HI:`F_CH_LO]; // [RL10] [RL13]
    wire [12:0] fields_next = {words, instr0_reg[`F_WCC],
                               instr0_reg[`F_INT], chan, chan,
                               word_b, instr0_reg[`F_A]}; // [RL18]

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            addr_a_reg <= 17'h00000;
            addr_c_reg <= 17'h00000;
            eff_reg <= 24'h000000;
            fields_reg <= 13'h0000;
        end else if (start_ok) begin
            addr_a_reg <= addr_a_next;
            addr_c_reg <= addr_c_next;
            eff_reg <= word_src;
            fields_reg <= fields_next; // [RL10] [RL12] [RL13]
        end
    end

    wire int_flag = fields_reg[9];
    wire wcc_flag = fields_reg[10];

    // Operation sequencing
    op_state_t state_reg;
    op_state_t state_next;
    wire active = state_reg == st_active;
    wire [7:0] delim = instr0_reg[7:0];
    wire char_match = delim8 ? (hwdata[7:0] == delim)
                             : (hwdata[5:0] == delim[5:0]);
    wire delim_hit = wr_char & active & char_match; // [RL9]
    wire op_end = active & (delim_hit | finish);

    always_comb begin
        case (state_reg)
            st_idle: state_next = start_ok ? st_active : st_idle;
            st_active: state_next = start_ok ? st_active
                                  : op_end ? st_idle : st_active; // [RL9]
            default: state_next = st_idle;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_reg <= st_idle;
        end else begin
            state_reg <= state_next;
        end
    end

    // Sticky events; a new event outweighs a write-one clear
    logic [3:0] status_reg;
    wire [3:0] events;
    assign events[`ST_DONE] = start_ok;
    assign events[`ST_DELIM] = delim_hit;
    assign events[`ST_CMPL] = op_end & ~start_ok & int_flag; // [RL11]
    assign events[`ST_CNTERR] = start & ~words_ok;
    wire [3:0] clear = wr_status ? hwdata[3:0] : 4'h0;
    wire [3:0] status_next = (status_reg & ~clear) | events;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            status_reg <= 4'h0;
        end else begin
            status_reg <= status_next;
        end
    end

    assign irq = |(status_reg & mask_reg);

    // Read side
    wire [31:0] fields_view = {17'h00000, wcc_flag & active, active,
                               fields_reg};
    wire [31:0] rd_value =
        (addr_reg == `OFF_INSTR0) ? {8'h00, instr0_reg} :
        (addr_reg == `OFF_INSTR1) ? {8'h00, instr1_reg} :
        (addr_reg == `OFF_INSTR2) ? {8'h00, instr2_reg} :
        (addr_reg == `OFF_IND) ? {8'h00, ind_reg} :
        (addr_reg == `OFF_IDX1) ? {15'h0000, idx_reg[0]} :
        (addr_reg == `OFF_IDX1 + 8'h04) ? {15'h0000, idx_reg[1]} :
        (addr_reg == `OFF_IDX1 + 8'h08) ? {15'h0000, idx_reg[2]} :
        (addr_reg == `OFF_CTRL) ? {22'h000000, ctrl_reg} :
        (addr_reg == `OFF_ADDR_A) ? {15'h0000, addr_a_reg} :
        (addr_reg == `OFF_ADDR_C) ? {15'h0000, addr_c_reg} :
        (addr_reg == `OFF_FIELDS) ? fields_view :
        (addr_reg == `OFF_STATUS) ? {28'h0000000, status_reg} :
        (addr_reg == `OFF_MASK) ? {28'h0000000, mask_reg} :
        (addr_reg == `OFF_EFF) ? {8'h00, eff_reg} :
        32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            hrdata_reg <= 32'h00000000;
        end else if (rd_en) begin
            hrdata_reg <= rd_value;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    chk_bus_wait: assert property ( // [RL1]
        accept |=> !hreadyout ##1 hreadyout)
        else $error("bus wait state wrong");

    chk_word_sum: assert property ( // [RL4]
        start_ok && is_word && !instr0_reg[`F_A] && word_b == 2'h2
        |=> addr_a_reg == {2'b00, 15'($past(instr0_reg[14:0])
                                    + $past(idx_reg[1][14:0]))})
        else $error("word address sum wrong");

    chk_shift_sum: assert property ( // [RL8]
        start_ok && fmt_bits == fmt_shift && word_b == 2'h3
        |=> addr_a_reg == {2'b00, 15'($past(instr0_reg[14:0])
                                    + $past(idx_reg[2][14:0]))})
        else $error("shift count sum wrong");

    chk_char_sum: assert property ( // [RL16]
        start_ok && is_char && instr0_reg[`F_CB_HI:`F_CB_LO] == 2'h2
        |=> addr_a_reg == 17'($past(instr0_reg[16:0]) + $past(idx_reg[1])))
        else $error("character address sum wrong");

    chk_indirect_swap: assert property ( // [RL15]
        start_ok && is_word && instr0_reg[`F_A]
        |=> eff_reg[17:0] == $past(ind_reg[17:0])
            && eff_reg[23:18] == $past(instr0_reg[23:18]))
        else $error("indirect word not applied");

    chk_biz_fold: assert property ( // [RL5]
        start_ok && is_biz && !biz_word
        && instr1_reg[`F_BF_HI:`F_BF_LO] == 2'h3
        |=> addr_a_reg == 17'($past(instr1_reg[16:0]) + $past(idx_reg[0])))
        else $error("flag three did not use index one");

    chk_biz_none: assert property ( // [RL6]
        start_ok && is_biz && !biz_word
        && instr2_reg[`F_BF_HI:`F_BF_LO] == 2'h0
        |=> addr_c_reg == $past(instr2_reg[16:0]))
        else $error("flag zero modified field C");

    chk_delim_end: assert property ( // [RL9]
        delim_hit && !start_ok
        |=> state_reg == st_idle && status_reg[`ST_DELIM])
        else $error("delimiter did not end operation");

    chk_cmpl_irq: assert property ( // [RL11]
        active && finish && !start_ok && int_flag
        && mask_reg[`ST_CMPL] && !wr_mask
        |=> status_reg[`ST_CMPL] ##1 irq)
        else $error("completion interrupt missing");

    chk_finish_idle: assert property ( // [RL11]
        active && finish && !start_ok |=> state_reg == st_idle)
        else $error("finish did not end operation");

    chk_status_clear: assert property ( // [RL11]
        wr_status
        |=> status_reg == ($past(status_reg) & ~$past(hwdata[3:0])))
        else $error("write-one clear wrong");

    chk_count_bad: assert property ( // [RL1]
        start && !finish && is_biz && words != 2'h3
        |=> status_reg[`ST_CNTERR] && $stable(state_reg))
        else $error("short business word count accepted");

    cov_indirect: cover property (
        start_ok && is_word && instr0_reg[`F_A]);
    cov_biz_run: cover property (
        start_ok && is_biz ##[1:40] delim_hit);
    cov_irq: cover property ($rose(irq));
    cov_count_error: cover property (start && !words_ok);

endmodule

/* File: sim/seq_model.sv */
// Sequencer side of the operand modifier: one AHB-Lite master.
// Assumes hready is the slave's hreadyout, all on one clock.
`timescale 1ns/10ps
module seq_model (
    input wire logic ref_clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    bit hung = 1'b0;

    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // A stall past the limit flags the bus as hung for the bench
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1)
            hung = 1'b1;
    endtask

    // Single word transfer; read data is taken at the closing edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
endmodule

/* File: sim/test_operand_address_modifier.sv */
// Self-checking bench for the operand modifier.
// Assumes the sequencer model drives the register bus.
`timescale 1ns/10ps
`include "operand_params.svh"
module test_operand_address_modifier;
    localparam logic [16:0] ix1 = 17'h10003;
    localparam logic [16:0] ix2 = 17'h00005;
    localparam logic [16:0] ix3 = 17'h1fff0;
    localparam logic [31:0] ones = 32'hffffffff;
    logic ref_clk;
    logic reset_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    int n_mismatch = 0;
    int checked = 0;

    operand_address_modifier i_operand_address_modifier (
        .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq));

    seq_model i_seq_model (
        .ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task close_out;
        if (n_mismatch == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        if (i_seq_model.hung) begin
            n_mismatch++;
            $display("ERROR %0t: bus hung", $time);
            close_out();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] e);
        checked++;
        if (got !== e) begin
            n_mismatch++;
            $display("ERROR %0t: got %h exp %h", $time, got, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_seq_model.xfer(1'b1, a, d, q);
    endtask

    task automatic chk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        logic [31:0] q;
        i_seq_model.xfer(1'b0, a, 32'h0, q);
        cmp(q & m, e);
    endtask

    // Let the edge's register updates land before looking at irq
    task automatic chk_irq(input logic e);
        #1;
        cmp({31'h0, irq}, {31'h0, e});
    endtask

    task automatic go(input logic [31:0] c);
        wr(`OFF_CTRL, c | 32'h100);
    endtask

    // Business flags fold 3 onto index one; word form keeps three
    function automatic logic [31:0] pick(input logic [1:0] f,
                                         input logic biz);
        pick = {15'h0, f == 2'h0 ? 17'h0 : f == 2'h2 ? ix2 :
                (f == 2'h3 && !biz) ? ix3 : ix1};
    endfunction

    task automatic t_reset;
        cmp({31'h0, irq}, 32'h0);
        cmp({31'h0, hresp}, 32'h0);
        chk(`OFF_CTRL, ones, 32'h10);
        chk(`OFF_MASK, ones, 32'h0);
        chk(`OFF_STATUS, ones, 32'h0);
        wr(8'h3c, ones);
        chk(8'h3c, ones, 32'h0);
        wr(`OFF_EFF, ones);
        chk(`OFF_EFF, ones, 32'h0);
        wr(`OFF_IDX1, {15'h0, ix1});
        wr(`OFF_IDX1 + 8'h04, {15'h0, ix2});
        wr(`OFF_IDX1 + 8'h08, {15'h0, ix3});
        chk(`OFF_IDX1 + 8'h08, ones, {15'h0, ix3});
    endtask

    task automatic t_word;
        logic [23:0] w;
        for (int b = 0; b < 4; b++) begin
            w = {4'hf, 3'h0, b[1:0], 15'h7ffe};
            wr(`OFF_INSTR0, {8'h0, w});
            go(32'h10);
            chk(`OFF_ADDR_A, ones,
                (pick(b[1:0], 1'b0) + 32'h7ffe) & 32'h7fff);
            chk(`OFF_EFF, ones, {8'h0, w});
        end
        chk(`OFF_STATUS, 32'h1, 32'h1);
    endtask

    task automatic t_indirect;
        wr(`OFF_INSTR0, 32'haa0123);
        wr(`OFF_IND, 32'hfefffd);
        go(32'h10);
        chk(`OFF_EFF, ones, 32'haafffd);
        chk(`OFF_ADDR_A, ones, 32'h0);
        chk(`OFF_FIELDS, 32'h1c0, 32'h140);
        wr(`OFF_INSTR0, 32'h38020);
        go(32'h12);
        chk(`OFF_ADDR_A, ones, 32'h10);
        wr(`OFF_INSTR0, 32'h9fffe);
        go(32'h11);
        chk(`OFF_ADDR_A, ones, 32'h3);
    endtask

    task automatic t_business;
        logic [1:0] f;
        for (int i = 0; i < 4; i++) begin
            f = i[1:0];
            wr(`OFF_INSTR1, {13'h0, f, 17'h1fff0});
            wr(`OFF_INSTR2, {13'h0, ~f, 17'h00010});
            go(32'h33);
            chk(`OFF_ADDR_A, ones,
                (pick(f, 1'b1) + 32'h1fff0) & 32'h1ffff);
            chk(`OFF_ADDR_C, ones,
                (pick(~f, 1'b1) + 32'h10) & 32'h1ffff);
        end
        wr(`OFF_INSTR1, 32'h5fff0);
        wr(`OFF_INSTR2, 32'h20010);
        go(32'h37);
        chk(`OFF_ADDR_A, ones, 32'h1);
        chk(`OFF_ADDR_C, ones, 32'h7);
        wr(`OFF_STATUS, 32'hf);
        go(32'h23);
        chk(`OFF_STATUS, 32'hf, 32'h8);
        chk(`OFF_ADDR_A, ones, 32'h1);
    endtask

    task automatic t_delim;
        wr(`OFF_STATUS, 32'hf);
        wr(`OFF_MASK, 32'h4);
        wr(`OFF_INSTR0, 32'h4025);
        go(32'h10);
        chk(`OFF_FIELDS, 32'h2000, 32'h2000);
        wr(`OFF_CHAR, 32'h26);
        chk(`OFF_STATUS, 32'hf, 32'h1);
        wr(`OFF_CHAR, 32'he5);
        chk(`OFF_STATUS, 32'hf, 32'h7);
        chk_irq(1'b1);
        chk(`OFF_FIELDS, 32'h2000, 32'h0);
        wr(`OFF_MASK, 32'h0);
        chk_irq(1'b0);
        wr(`OFF_MASK, 32'h4);
        wr(`OFF_STATUS, 32'h4);
        chk_irq(1'b0);
        chk(`OFF_STATUS, 32'hf, 32'h3);
        wr(`OFF_STATUS, 32'hf);
        go(32'h18);
        wr(`OFF_CHAR, 32'he5);
        chk(`OFF_STATUS, 32'hf, 32'h1);
        wr(`OFF_CHAR, 32'h25);
        chk(`OFF_STATUS, 32'hf, 32'h7);
    endtask

    task automatic t_finish;
        wr(`OFF_STATUS, 32'hf);
        wr(`OFF_INSTR0, 32'h1a000);
        go(32'h10);
        chk(`OFF_FIELDS, 32'h7f8, 32'h4d8);
        chk(`OFF_FIELDS, 32'h6000, 32'h6000);
        wr(`OFF_CTRL, 32'h210);
        chk(`OFF_STATUS, 32'hf, 32'h1);
        chk(`OFF_FIELDS, 32'h6000, 32'h0);
        wr(`OFF_INSTR0, 32'h1e000);
        go(32'h10);
        wr(`OFF_CTRL, 32'h210);
        chk(`OFF_STATUS, 32'hf, 32'h5);
        chk_irq(1'b1);
    endtask

    initial begin
        reset_n = 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_word();
        t_indirect();
        t_business();
        t_delim();
        t_finish();
        close_out();
    end
endmodule
